/* File: inc/clock_fanout_defs.vh */
// constants for the clock fanout, select and halt block
// assumes every pin input is resynchronised to mclk before use
//
// What this block does
// - nine outputs copy the selected input clock while enabled and running
// - select 0 routes the primary clock, select 1 the alternate clock
// - halt control is sampled on the falling edge of the selected clock
// - halt control 0 parks outputs low; 1 lets them toggle
// - outputs stop or restart only during their low phase, never a runt pulse
// - enable 0 floats every output regardless of halt; 1 drives them
// - select, enable and halt controls all default to 1 when unconnected
`ifndef CLOCK_FANOUT_DEFS_VH
`define CLOCK_FANOUT_DEFS_VH

// number of fanout outputs
`define FANOUT_COUNT 9

// source select encoding
`define SEL_PRIMARY 1'h0
`define SEL_ALTERNATE 1'h1

// reset values: controls take their unconnected default
`define SELECT_RESET 1'h1
`define ENABLE_RESET 1'h1
`define RUN_RESET 1'h1
`define CLOCK_RESET 1'h0

`endif

/* File: src/pin_sync.v */
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to mclk; reset value is per bit
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire rst_b,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pin_sync

/* File: src/clock_fanout_select_gate.v */
// clock fanout: two-way source select, falling-edge halt gate, output float
// assumes both input clocks are well below half of mclk; all pins are asynchronous
// assumes the pad ring floats a pin while its fanout_drive_b bit is high
// assumes select only changes while the outputs are halted, as a changeover can glitch
// limitation: an input clock edge reaches the pins two to three mclk cycles late
// limitation: pulses shorter than one mclk cycle may be lost or stretched
`timescale 1ns/1ps
`include "clock_fanout_defs.vh"
module clock_fanout_select_gate #(
  parameter NUM_OUTPUTS = `FANOUT_COUNT
) (
  input wire mclk,
  input wire rst_b,
  input wire primary_clock_in,
  input wire alternate_clock_in,
  input wire source_select,
  input wire output_enable,
  input wire run_enable,
  output reg [NUM_OUTPUTS-1:0] fanout_clock_outputs,
  output reg [NUM_OUTPUTS-1:0] fanout_drive_b
);
  // halt gate states; codes match the level of the halt control
  localparam GATE_PARKED = 1'h0;
  localparam GATE_RUNNING = 1'h1;

  // pick the routed input clock from the select level
  function pick_source;
    input select_level;
    input primary_level;
    input alternate_level;
    begin
      case (select_level)
        `SEL_PRIMARY: begin
          pick_source = primary_level;
        end
        `SEL_ALTERNATE: begin
          pick_source = alternate_level;
        end
        default: begin
          pick_source = alternate_level;
        end
      endcase
    end
  endfunction

  // high when the routed clock was high one mclk ago and is low now
  function is_falling;
    input previous_level;
    input current_level;
    begin
      if (previous_level && !current_level) begin
        is_falling = 1'h1;
      end else begin
        is_falling = 1'h0;
      end
    end
  endfunction

  // one level copied to every output pin
  function [NUM_OUTPUTS-1:0] spread;
    input level;
    begin
      spread = {NUM_OUTPUTS{level}};
    end
  endfunction

  // synchronised pins; nothing reads a pin before its second flop
  wire pri_sync;
  wire alt_sync;
  wire sel_sync;
  wire oe_sync;
  wire run_sync;

  // routed clock and its value one mclk earlier
  reg sel_clk;
  reg sel_clk_prev_reg;

  // one-cycle strobe where the routed clock went low
  reg sel_fall;

  // halt gate state; moves only where the routed clock falls
  reg gate_reg;
  reg gate_next;

  // run level the output gate uses this cycle
  reg run_next;

  // next values of the clock pins
  reg out_next;
  reg [NUM_OUTPUTS-1:0] clock_out_next;

  // next value of the float control, one bit per pin
  reg [NUM_OUTPUTS-1:0] drive_b_next;

  // input clocks reset low, so no false edge follows reset
  pin_sync #(
    .WIDTH(1),
    .RESET_VALUE(`CLOCK_RESET)
  ) u_primary_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(primary_clock_in),
    .sync_out(pri_sync)
  );

  pin_sync #(
    .WIDTH(1),
    .RESET_VALUE(`CLOCK_RESET)
  ) u_alternate_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(alternate_clock_in),
    .sync_out(alt_sync)
  );

  // controls reset to their unconnected default, as a pull-up would leave them
  pin_sync #(
    .WIDTH(1),
    .RESET_VALUE(`SELECT_RESET)
  ) u_select_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(source_select),
    .sync_out(sel_sync)
  );

  pin_sync #(
    .WIDTH(1),
    .RESET_VALUE(`ENABLE_RESET)
  ) u_enable_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(output_enable),
    .sync_out(oe_sync)
  );

  pin_sync #(
    .WIDTH(1),
    .RESET_VALUE(`RUN_RESET)
  ) u_run_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(run_enable),
    .sync_out(run_sync)
  );

  // source mux; not glitch free, so a changeover wants the outputs halted
  always @* begin
    sel_clk = pick_source(sel_sync, pri_sync, alt_sync);
  end

  // falling edge of the routed clock as mclk sees it
  always @* begin
    sel_fall = is_falling(sel_clk_prev_reg, sel_clk);
  end

  // halt gate: the control is taken only at a falling edge, so in the low phase
  always @* begin
    gate_next = gate_reg;
    case (gate_reg)
      GATE_RUNNING: begin
        if (sel_fall && (run_sync == 1'h0)) begin
          gate_next = GATE_PARKED;
        end
      end
      GATE_PARKED: begin
        if (sel_fall && (run_sync == 1'h1)) begin
          gate_next = GATE_RUNNING;
        end
      end
      default: begin
        gate_next = GATE_RUNNING;
      end
    endcase
    run_next = (gate_next == GATE_RUNNING);
  end

  // gated copy; a parked gate holds every clock pin low
  always @* begin
    out_next = sel_clk & run_next;
    clock_out_next = spread(out_next);
  end

  // float control; independent of the halt gate, so it wins over a halt
  always @* begin
    drive_b_next = spread(~oe_sync);
  end

  // edge history of the routed clock
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sel_clk_prev_reg <= `CLOCK_RESET;
    end else begin
      sel_clk_prev_reg <= sel_clk;
    end
  end

  // gate state; starts running, like an open halt pin
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gate_reg <= `RUN_RESET;
    end else begin
      gate_reg <= gate_next;
    end
  end

  // clock pins straight from flops, so no mux glitch reaches a load
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fanout_clock_outputs <= {NUM_OUTPUTS{`CLOCK_RESET}};
    end else begin
      fanout_clock_outputs <= clock_out_next;
    end
  end

  // drive controls straight from flops as well
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fanout_drive_b <= {NUM_OUTPUTS{~`ENABLE_RESET}};
    end else begin
      fanout_drive_b <= drive_b_next;
    end
  end
endmodule // clock_fanout_select_gate

/* File: dv/fanout_checker.sv */
// checker: copy, halt gate and float timing at the fanout pins
// assumes three mclk edges from any pin to the outputs
`timescale 1ns/1ps
module fanout_checker #(parameter NUM_OUTPUTS = 9) (
  input wire mclk,
  input wire rst_b,
  input wire primary_clock_in,
  input wire alternate_clock_in,
  input wire source_select,
  input wire output_enable,
  input wire run_enable,
  input wire [NUM_OUTPUTS-1:0] fanout_clock_outputs,
  input wire [NUM_OUTPUTS-1:0] fanout_drive_b
);
  localparam N = NUM_OUTPUTS;
  wire [N-1:0] f = fanout_clock_outputs, d = fanout_drive_b;
  wire s = source_select ? alternate_clock_in : primary_clock_in;
  reg p1, p2, c3, h1, h2, h3;
  // pin-side mirror; halt only taken where the selected clock falls
  always @(posedge mclk or negedge rst_b)
    if (!rst_b) {p1, p2, c3, h1, h2, h3} <= 6'h07;
    else {p1, p2, c3, h1, h2, h3} <= {s, p1, p2, p1 && !s ? run_enable : h1, h1, h2};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_exact_copy: assert property (f == {N{c3 & h3}}) else $error("copy");
  a_same_level: assert property (&f || !(|f)) else $error("split");
  a_start_low: assert property ($rose(f[0]) |-> $rose(c3)) else $error("runt");
  a_stop_fall: assert property ($fell(f[0]) |-> $fell(c3)) else $error("stop");
  a_float_delay: assert property (d == {N{!$past(output_enable, 3)}}) else $error("z");
  a_float_same: assert property (&d || !(|d)) else $error("split");
  // looks one edge on: the flops are unknown until the first edge in reset
  a_reset_default: assert property (disable iff (1'b0) !rst_b |=> d == 0 && f == 0)
    else $error("reset");
  c_halted: cover property (c3 && !h3);
  c_float: cover property (d[0]);
  c_alternate: cover property ($rose(f[0]) && source_select);
endmodule // fanout_checker
bind clock_fanout_select_gate fanout_checker #(.NUM_OUTPUTS(NUM_OUTPUTS)) i_chk (.*);

/* File: dv/fanout_far_side.sv */
// far side: two free-running sources and the loaded output pins
// assumes drive_b low means the pin is driven
`timescale 1ns/1ps
module fanout_far_side (
  output reg primary_clock_in,
  output reg alternate_clock_in,
  input wire [8:0] fanout_clock_outputs,
  input wire [8:0] fanout_drive_b,
  output wire [8:0] load_pins
);
  // start off the mclk grid so no edge races a sample
  initial begin
    {primary_clock_in, alternate_clock_in} = 2'h0;
    #413;
    fork
      forever #170 primary_clock_in = !primary_clock_in;
      forever #235 alternate_clock_in = !alternate_clock_in;
    join
  end
  // a released pin floats
  bufif0 pin_buf[8:0] (load_pins, fanout_clock_outputs, fanout_drive_b);
endmodule // fanout_far_side

/* File: dv/test_clock_fanout_select_gate.sv */
// bench: random halt, float and source changes against a queue model
// assumes the far-side model runs both input clocks
`timescale 1ns/1ps
module test_clock_fanout_select_gate;
  reg mclk = 1'h0, rst_b = 1'h0, source_select = 1'h1, output_enable = 1'h1, run_enable = 1'h1;
  wire primary_clock_in, alternate_clock_in;
  wire [8:0] fanout_clock_outputs, fanout_drive_b, load_pins;
  wire c = source_select ? alternate_clock_in : primary_clock_in;
  integer n_mismatch = 0, compares = 0, seed = 44, hold = 1, i, w, m[$];
  reg [8:0] want;
  clock_fanout_select_gate i_dut (.*);
  fanout_far_side i_far (.*);
  initial forever #25 mclk = !mclk;
  task chk(input [8:0] got, input [8:0] exp);
    compares++;
    if (got !== exp) n_mismatch++;
    if (got !== exp) $display("wrong value pins exp %b seen %b", exp, got);
  endtask
  task finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // model: pins taken at an edge reach the outputs two edges later
  always @(posedge mclk) begin
    if (m.size() > 0 && m[$][1] && !c) hold = run_enable;
    m.push_back({!output_enable, c, c & hold[0]});
    // compare once the outputs launched at this edge have settled
    #2;
    if (!rst_b) m = {};
    if (m.size() > 2) begin
      want = m[$-2][2] ? 9'hZ : {9{m[$-2][0]}};
      chk(load_pins, want);
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_b = 1'h1;
    for (i = 0; i < 40; i++) begin
      repeat (20 + {$random(seed)} % 40) @(posedge mclk);
      if (i % 3 == 0) begin
        // bounded wait for an edge that sees the routed clock low after high
        w = 0;
        while (c !== 1'h1 && w < 40) begin
          @(posedge mclk);
          w++;
        end
        while (c !== 1'h0 && w < 40) begin
          @(posedge mclk);
          w++;
        end
        if (w >= 40) begin
          n_mismatch++;
          finish_test;
        end
      end
      @(posedge mclk);
      #1;
      if (i % 3 == 0) run_enable = $random(seed);
      if (i % 3 == 1) output_enable = $random(seed);
      if (i % 3 == 2 && !run_enable) source_select = !source_select;
    end
    finish_test;
  end
  // hang guard
  initial begin
    repeat (9000) @(posedge mclk);
    n_mismatch++;
    finish_test;
  end
endmodule // test_clock_fanout_select_gate
